// ### bench/drw_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus master and RAM array model
// ----------------------------------------------------------------
module drw_bus_model (
    input wire logic clk_in,
    input wire logic ready_in,
    input wire logic [3:0] cas_n_in,
    input wire logic [6:0] ma_in,
    input wire logic we_n_in,
    input wire logic [7:0] wdata_in,
    output logic bclk_out,
    output logic sm1_out,
    output logic smemr_out,
    output logic pdbin_out,
    output logic pwr_n_out,
    output logic mwrt_out,
    output logic refresh_n_out,
    output logic [15:0] addr_out,
    output logic [7:0] do_out,
    output logic [7:0] rdata_out
);
    logic [7:0] mem [0:65535];
    logic [6:0] row_r;
    logic [1:0] blk;
    logic [15:0] ra;
    int cnt = 0;

    // Idle bus at time zero
    initial begin
        {bclk_out, sm1_out, smemr_out, pdbin_out, mwrt_out} = 5'h00;
        {pwr_n_out, refresh_n_out} = 2'h3;
        addr_out = 16'h0000;
        do_out = 8'h00;
    end

    // Bus clock runs free; row is taken while no column strobe is low
    always @(posedge clk_in) begin
        cnt <= (cnt == 9) ? 0 : cnt + 1;
        if (cnt == 9) bclk_out <= ~bclk_out;
        if (cas_n_in == 4'hF) row_r <= ma_in;
        if (!we_n_in && cas_n_in != 4'hF) mem[ra] <= wdata_in;
    end

    // Unselected array shows inverted data so stale values never match
    assign blk = cas_n_in[0] ? (cas_n_in[1] ? (cas_n_in[2] ? 2'h3 : 2'h2) : 2'h1) : 2'h0;
    assign ra = {blk, ma_in, row_r};
    assign rdata_out = (cas_n_in != 4'hF) ? mem[ra] : ~mem[ra];

    // Kind 0 read, 1 write, 2 panel write, 3 fetch with strobe, 4 fetch without
    task automatic bus_cycle(input int kind, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_in);
        addr_out <= a;
        do_out <= d;
        smemr_out <= (kind == 0 || kind >= 3);
        sm1_out <= (kind >= 3);
        pdbin_out <= (kind == 0 || kind >= 3);
        pwr_n_out <= (kind != 1);
        mwrt_out <= (kind == 2);
        repeat (24) @(posedge clk_in);
        // Wait states are honoured, but never forever
        for (n = 0; n < 2000 && ready_in !== 1'b1; n++) @(posedge clk_in);
        // A master stuck in wait states fails the run at once
        if (n >= 2000) begin
            drw_refresh_ctrl_test.mismatches++;
            drw_refresh_ctrl_test.results();
        end
        pdbin_out <= 1'b0;
        pwr_n_out <= 1'b1;
        mwrt_out <= 1'b0;
        refresh_n_out <= (kind != 3);
        if (kind == 3) sm1_out <= 1'b0;
        repeat (kind >= 3 ? 40 : 4) @(posedge clk_in);
        {refresh_n_out, sm1_out, smemr_out} <= 3'h4;
        addr_out <= ~a;
        do_out <= ~d;
        repeat (12) @(posedge clk_in);
    endtask : bus_cycle
endmodule : drw_bus_model

// ### bench/drw_refresh_ctrl_test.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module drw_refresh_ctrl_test;
    logic clk, reset_n, ext_clr_n, phantom_n, dma, sel, div8, ph, w;
    logic bclk, sm1, smemr, pdbin, pwr_n, mwrt, refresh_n;
    logic ready, ras_n, we_n, di_oe, rf_act, flag_q, oe_q, ras_seen, cas_seen, oe_seen;
    logic [15:0] addr, av;
    logic [7:0] dout, rdata, wdata, di, di_q, dv;
    logic [3:0] cas_n;
    logic [6:0] ma, row_ctr;
    logic [7:0] exp_row[$], exp_di[$];
    int mismatches = 0, cmp_count = 0, n, t, seed;

    drw_refresh_ctrl DUT (
        .CLK_IN(clk), .RESET_N_IN(reset_n), .BUS_CLOCK_IN(bclk), .EXT_CLR_N_IN(ext_clr_n),
        .SM1_IN(sm1), .SMEMR_IN(smemr), .PDBIN_IN(pdbin), .PWR_N_IN(pwr_n), .MWRT_IN(mwrt),
        .REFRESH_N_IN(refresh_n), .PHANTOM_N_IN(phantom_n), .DMA_ACTIVE_IN(dma),
        .BOARD_SEL_IN(sel), .DIV8_SEL_IN(div8), .ADDR_IN(addr), .DO_IN(dout),
        .RAM_RDATA_IN(rdata), .PREADY_OUT(ready), .RAS_N_OUT(ras_n), .CAS_N_OUT(cas_n),
        .MA_OUT(ma), .WE_N_OUT(we_n), .RAM_WDATA_OUT(wdata), .DI_OUT(di),
        .DI_OE_OUT(di_oe), .REFRESH_CYCLE_ACTIVE_OUT(rf_act)
    );

    drw_bus_model bm (
        .clk_in(clk), .ready_in(ready), .cas_n_in(cas_n), .ma_in(ma), .we_n_in(we_n),
        .wdata_in(wdata), .bclk_out(bclk), .sm1_out(sm1), .smemr_out(smemr),
        .pdbin_out(pdbin), .pwr_n_out(pwr_n), .mwrt_out(mwrt), .refresh_n_out(refresh_n),
        .addr_out(addr), .do_out(dout), .rdata_out(rdata)
    );

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // Monitor: each observed result takes the oldest note off its queue
    always @(posedge clk) begin
        if (reset_n === 1'b1 && rf_act === 1'b1 && flag_q !== 1'b1) begin
            compare("refresh row", exp_row.size() ? exp_row.pop_front() : 8'hXX, {1'b0, ma});
        end
        // Data is judged at the last cycle the driver is on, when the master samples it
        if (oe_q === 1'b1 && di_oe === 1'b0) begin
            compare("read data", exp_di.size() ? exp_di.pop_front() : 8'hXX, di_q);
        end
        flag_q <= rf_act;
        oe_q <= di_oe;
        di_q <= di;
        if (ras_n === 1'b0) ras_seen <= 1'b1;
        if (cas_n !== 4'hF) cas_seen <= 1'b1;
        if (di_oe === 1'b1) oe_seen <= 1'b1;
    end

    initial begin
        {reset_n, ext_clr_n, phantom_n, dma, sel, div8} = 6'h18;
        {flag_q, oe_q, ras_seen, cas_seen, oe_seen} = 5'h00;
        row_ctr = 7'h00;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        seed = $urandom(55);
        repeat (6) @(posedge clk);
        compare("reset outputs", 8'hFE, {ready, ras_n, cas_n, we_n, rf_act});
        $display("test reset done");
        // Random writes read back, some with the overlay input active
        sel <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            av = 16'($urandom);
            dv = 8'($urandom);
            ph = 1'($urandom);
            bm.bus_cycle(1 + i % 2, av, dv);
            phantom_n <= ph;
            if (ph) exp_di.push_back(dv);
            oe_seen = 1'b0;
            bm.bus_cycle(0, av, 8'h00);
            if (!ph) compare("overlay driver", 8'h00, {7'h00, oe_seen});
        end
        phantom_n <= 1'b1;
        $display("test write read done");
        // DMA accesses to an unselected board refresh a row only
        sel <= 1'b0;
        dma <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            {ras_seen, cas_seen} = 2'h0;
            bm.bus_cycle(k, 16'h1234, 8'h5A);
            compare("dma row strobe", 8'h01, {7'h00, ras_seen});
            compare("dma column strobe", 8'h00, {7'h00, cas_seen});
        end
        dma <= 1'b0;
        $display("test dma done");
        // Both fetch styles trigger a refresh of the next row
        for (int k = 3; k < 5; k++) begin
            exp_row.push_back({1'b0, row_ctr});
            row_ctr++;
            cas_seen = 1'b0;
            bm.bus_cycle(k, 16'h0000, 8'h00);
            compare("refresh column strobe", 8'h00, {7'h00, cas_seen});
        end
        $display("test fetch refresh done");
        // Idle bus: watchdog raises wait states, then forces a refresh
        sel <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            div8 <= k[0];
            exp_row.push_back({1'b0, row_ctr});
            row_ctr++;
            bm.bus_cycle(1, 16'h00FF, 8'h00);
            w = 1'b0;
            cas_seen = 1'b0;
            for (n = 0; n < 3000 && rf_act !== 1'b1; n++) begin
                @(posedge clk);
                if (ready === 1'b0) w = 1'b1;
            end
            if (n >= 3000) begin
                mismatches++;
                results();
            end
            t = 80 << k;
            compare("forced refresh delay", 8'h01, {7'h00, n >= 7 * t - 80 && n <= 8 * t + 40});
            compare("wait before refresh", 8'h01, {7'h00, w});
            for (n = 0; n < 100 && rf_act === 1'b1; n++) begin
                if (ready !== 1'b0) w = 1'b0;
                @(posedge clk);
            end
            compare("wait held", 8'h01, {7'h00, w});
            compare("forced refresh column strobe", 8'h00, {7'h00, cas_seen});
            repeat (3) @(posedge clk);
            compare("ready after refresh", 8'h01, {7'h00, ready});
        end
        div8 <= 1'b0;
        $display("test watchdog done");
        // External clear returns to idle and restarts the row counter
        ext_clr_n <= 1'b0;
        sel <= 1'b0; // Unselected, so the fetch below puts no read data out
        repeat (4) @(posedge clk);
        compare("clear outputs", 8'hFE, {ready, ras_n, cas_n, we_n, rf_act});
        ext_clr_n <= 1'b1;
        exp_row.push_back(8'h00);
        bm.bus_cycle(3, 16'h0000, 8'h00);
        repeat (20) @(posedge clk);
        compare("notes left", 8'h00, 8'(exp_row.size() + exp_di.size()));
        $display("test clear done");
        results();
    end
endmodule : drw_refresh_ctrl_test

// ### rtl/drw_params.svh
`ifndef DRW_PARAMS_SVH
`define DRW_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DRW_CLK_NS 25
`define DRW_RAS_NS 225
// Least time, so round up to whole cycles
`define DRW_RAS_CYCLES ((`DRW_RAS_NS + `DRW_CLK_NS - 1) / `DRW_CLK_NS)
// Row-to-column delay in cycles before the column strobe may fall
`define DRW_CAS_DLY 3
`define DRW_CNT_W 4

// ----------------------------------------------------------------
// Widths and field positions
// ----------------------------------------------------------------
`define DRW_SR_W 8
`define DRW_WAIT_STAGE 6
`define DRW_FORCE_STAGE 7
`define DRW_DIV_W 3
`define DRW_DIV4_BIT 1
`define DRW_DIV8_BIT 2
`define DRW_ROW_W 7
`define DRW_ADDR_W 16
`define DRW_COL_LSB 7
`define DRW_BLK_LSB 14
`define DRW_DATA_W 8
`define DRW_BLOCKS 4
`define DRW_CTL_W 12
`define DRW_SYNC_W (`DRW_CTL_W + `DRW_ADDR_W + 2 * `DRW_DATA_W)

`endif

// ### rtl/drw_pkg.sv
package drw_pkg;
    // Row-strobe sequencer
    typedef enum logic [1:0] {
        DRW_IDLE,
        DRW_RAS,
        DRW_END
    } drw_seq_e;
endpackage : drw_pkg

// ### rtl/drw_refresh_ctrl.sv
// Function
// - Bus clock divided by four gives a 2 us timer tick.
// - Without refresh or memory cycle for 16 us, start refresh alone.
// - Timer advances per tick rise; after seventh, ready low when tick low.
// - Eighth advance starts refresh cycle and keeps ready low.
// - Wait latch set on seventh stage rise holds ready low.
// - Row-strobe start pulse clears divider and timer shift register.
// - End-of-cycle pulse clears refresh flag and wait latch.
// - Option divides bus clock by eight, forcing refresh every 32 us.
// - During DMA every write, read strobe or memory read raises row strobe.
// - Column strobe suppressed while board not selected.
// - Read-data driver off while overlay input is active.
// - External clear resets all logic.
// - Memory-write strobe writes output data bus byte into memory.
// - Refresh drives 7-bit counter row onto address lines during row strobe.
// - Refresh end releases row address, increments counter; no column strobe.
// - Refresh strobe going active latches a refresh trigger.
// - Read strobe falling during opcode fetch starts a refresh.
`timescale 1ns/1ps
`include "drw_params.svh"
module drw_refresh_ctrl (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic BUS_CLOCK_IN,
    input wire logic EXT_CLR_N_IN,
    input wire logic SM1_IN,
    input wire logic SMEMR_IN,
    input wire logic PDBIN_IN,
    input wire logic PWR_N_IN,
    input wire logic MWRT_IN,
    input wire logic REFRESH_N_IN,
    input wire logic PHANTOM_N_IN,
    input wire logic DMA_ACTIVE_IN,
    input wire logic BOARD_SEL_IN,
    input wire logic DIV8_SEL_IN,
    input wire logic [`DRW_ADDR_W-1:0] ADDR_IN,
    input wire logic [`DRW_DATA_W-1:0] DO_IN,
    input wire logic [`DRW_DATA_W-1:0] RAM_RDATA_IN,
    output logic PREADY_OUT,
    output logic RAS_N_OUT,
    output logic [`DRW_BLOCKS-1:0] CAS_N_OUT,
    output logic [`DRW_ROW_W-1:0] MA_OUT,
    output logic WE_N_OUT,
    output logic [`DRW_DATA_W-1:0] RAM_WDATA_OUT,
    output logic [`DRW_DATA_W-1:0] DI_OUT,
    output logic DI_OE_OUT,
    output logic REFRESH_CYCLE_ACTIVE_OUT
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [`DRW_SYNC_W-1:0] sync_q;
    logic bclk, clr, sm1, smemr, pdbin, pwr_n, mwrt, refresh_n;
    logic phantom_n, dma, bsel, div8;
    logic [`DRW_ADDR_W-1:0] addr;
    logic [`DRW_DATA_W-1:0] dout, rdata;

    drw_sync #(.W(`DRW_SYNC_W)) u_sync (
        .CLK_IN(CLK_IN),
        .RESET_N_IN(RESET_N_IN),
        .d_in({BUS_CLOCK_IN, EXT_CLR_N_IN, SM1_IN, SMEMR_IN, PDBIN_IN, PWR_N_IN,
               MWRT_IN, REFRESH_N_IN, PHANTOM_N_IN, DMA_ACTIVE_IN, BOARD_SEL_IN,
               DIV8_SEL_IN, ADDR_IN, DO_IN, RAM_RDATA_IN}),
        .q_out(sync_q)
    );

    // Clear stays asserted for two cycles after reset release, by design
    assign {bclk, clr, sm1, smemr, pdbin, pwr_n, mwrt, refresh_n, phantom_n, dma,
            bsel, div8, addr, dout, rdata} = {sync_q[`DRW_SYNC_W-1],
            ~sync_q[`DRW_SYNC_W-2], sync_q[`DRW_SYNC_W-3:0]};

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    drw_pkg::drw_seq_e state_r, state_nxt;
    logic [`DRW_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [`DRW_DIV_W-1:0] div_r, div_nxt;
    logic [`DRW_SR_W-1:0] sr_r, sr_nxt;
    logic [`DRW_ROW_W-1:0] row_r, row_nxt;
    logic [`DRW_DATA_W-1:0] di_r, di_nxt, wd_r, wd_nxt;
    logic bclk_prev_r, tick_prev_r, rfn_prev_r, dbin_prev_r, acc_prev_r;
    logic rf_pend_r, rf_pend_nxt, mem_pend_r, mem_pend_nxt;
    logic rf_act_r, rf_act_nxt, wait_r, wait_nxt;
    logic tick, adv, acc, rf_trig, rf_req, start, start_rf, end_pulse, cas_en;

    // Advance the row counter by one, wrapping over 128 rows
    function automatic logic [`DRW_ROW_W-1:0] drw_inc(input logic [`DRW_ROW_W-1:0] v);
        drw_inc = v + `DRW_ROW_W'(1);
    endfunction : drw_inc

    // ----------------------------------------------------------------
    // Timer tick and event decode
    // ----------------------------------------------------------------
    always_comb begin
        tick = div8 ? div_r[`DRW_DIV8_BIT] : div_r[`DRW_DIV4_BIT];
        adv = tick & ~tick_prev_r;
        // DMA cycles refresh a row whether or not the board is selected
        acc = (dma & (pdbin | ~pwr_n | smemr)) | (bsel & (smemr | ~pwr_n | mwrt));
        rf_trig = (rfn_prev_r & ~refresh_n)
                | (dbin_prev_r & ~pdbin & sm1);
        rf_req = rf_pend_r | sr_r[`DRW_FORCE_STAGE];
        start = (state_r == drw_pkg::DRW_IDLE) & (rf_req | mem_pend_r);
        start_rf = start & rf_req; // Refresh wins over a waiting access
        end_pulse = (state_r == drw_pkg::DRW_END);
        cas_en = (state_r == drw_pkg::DRW_RAS) & (cnt_r >= `DRW_CNT_W'(`DRW_CAS_DLY));
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        row_nxt = row_r;
        // Clear wins over advance so a started cycle always restarts the watchdog
        div_nxt = (bclk & ~bclk_prev_r) ? div_r + `DRW_DIV_W'(1) : div_r;
        sr_nxt = adv ? {sr_r[`DRW_SR_W-2:0], 1'b1} : sr_r;
        if (start) begin
            div_nxt = '0;
            sr_nxt = '0;
        end
        unique case (state_r)
            drw_pkg::DRW_IDLE: begin
                if (start) begin
                    state_nxt = drw_pkg::DRW_RAS;
                    cnt_nxt = '0;
                end
            end
            drw_pkg::DRW_RAS: begin
                cnt_nxt = cnt_r + `DRW_CNT_W'(1);
                if (cnt_r == `DRW_CNT_W'(`DRW_RAS_CYCLES - 1)) begin
                    state_nxt = drw_pkg::DRW_END;
                end
            end
            drw_pkg::DRW_END: begin
                state_nxt = drw_pkg::DRW_IDLE;
                if (rf_act_r) begin
                    row_nxt = drw_inc(row_r);
                end
            end
        endcase
        // Set wins over clear on every pending flag
        rf_pend_nxt = (rf_pend_r & ~start_rf) | rf_trig;
        mem_pend_nxt = (mem_pend_r & ~(start & ~rf_req)) | (acc & ~acc_prev_r);
        rf_act_nxt = (rf_act_r & ~end_pulse) | start_rf;
        wait_nxt = (wait_r & ~end_pulse)
                 | (sr_nxt[`DRW_WAIT_STAGE] & ~sr_r[`DRW_WAIT_STAGE]);
        // Read data is caught while the column strobe is low
        di_nxt = cas_en & ~rf_act_r & bsel ? rdata : di_r;
        wd_nxt = dout;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_r <= drw_pkg::DRW_IDLE;
            cnt_r <= '0;
            div_r <= '0;
            sr_r <= '0;
            row_r <= '0;
            rf_pend_r <= 1'b0;
            mem_pend_r <= 1'b0;
            rf_act_r <= 1'b0;
            wait_r <= 1'b0;
            di_r <= '0;
            wd_r <= '0;
            {bclk_prev_r, tick_prev_r, rfn_prev_r, dbin_prev_r, acc_prev_r} <= 5'h1F;
        end else if (clr) begin
            state_r <= drw_pkg::DRW_IDLE;
            cnt_r <= '0;
            div_r <= '0;
            sr_r <= '0;
            row_r <= '0;
            rf_pend_r <= 1'b0;
            mem_pend_r <= 1'b0;
            rf_act_r <= 1'b0;
            wait_r <= 1'b0;
            di_r <= '0;
            wd_r <= '0;
            {bclk_prev_r, tick_prev_r, rfn_prev_r, dbin_prev_r, acc_prev_r} <= 5'h1F;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            div_r <= div_nxt;
            sr_r <= sr_nxt;
            row_r <= row_nxt;
            rf_pend_r <= rf_pend_nxt;
            mem_pend_r <= mem_pend_nxt;
            rf_act_r <= rf_act_nxt;
            wait_r <= wait_nxt;
            di_r <= di_nxt;
            wd_r <= wd_nxt;
            {bclk_prev_r, tick_prev_r, rfn_prev_r, dbin_prev_r, acc_prev_r} <=
                {bclk, tick, refresh_n, pdbin, acc};
        end
    end

    // ----------------------------------------------------------------
    // Memory and bus outputs
    // ----------------------------------------------------------------
    always_comb begin
        RAS_N_OUT = ~(state_r == drw_pkg::DRW_RAS);
        // Column strobe never falls for refresh or an unselected access
        CAS_N_OUT = '1;
        if (cas_en & bsel & ~rf_act_r) begin
            CAS_N_OUT[addr[`DRW_BLK_LSB +: $clog2(`DRW_BLOCKS)]] = 1'b0;
        end
        if (rf_act_r) begin
            MA_OUT = row_r;
        end else if (cas_en) begin
            MA_OUT = addr[`DRW_COL_LSB +: `DRW_ROW_W];
        end else begin
            MA_OUT = addr[`DRW_ROW_W-1:0];
        end
        WE_N_OUT = ~(bsel & (mwrt | ~pwr_n));
        RAM_WDATA_OUT = wd_r;
        DI_OUT = di_r;
        DI_OE_OUT = pdbin & bsel & phantom_n;
        // Ready held low from stage seven until the forced cycle ends
        PREADY_OUT = ~((sr_r[`DRW_WAIT_STAGE] & ~tick) | sr_r[`DRW_FORCE_STAGE] | wait_r);
        REFRESH_CYCLE_ACTIVE_OUT = rf_act_r;
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN || clr);

    property p_ras_width;
        $fell(RAS_N_OUT) |-> (!RAS_N_OUT)[*8] ##1 !RAS_N_OUT ##1 RAS_N_OUT;
    endproperty
    a_ras_width: assert property (p_ras_width) else $error("row strobe width wrong");

    property p_start_clear;
        start |=> (sr_r == '0) && (div_r == '0);
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("timer not cleared");

    property p_adv;
        adv && !start |=> sr_r == {$past(sr_r[`DRW_SR_W-2:0]), 1'b1};
    endproperty
    a_adv: assert property (p_adv) else $error("timer did not advance on tick");

    property p_wait7;
        sr_r[`DRW_WAIT_STAGE] && !tick |-> !PREADY_OUT;
    endproperty
    a_wait7: assert property (p_wait7) else $error("ready not low after stage seven");

    property p_force;
        sr_r[`DRW_FORCE_STAGE] && state_r == drw_pkg::DRW_IDLE |-> !PREADY_OUT ##1 rf_act_r;
    endproperty
    a_force: assert property (p_force) else $error("forced refresh missing");

    property p_latch;
        $rose(sr_r[`DRW_WAIT_STAGE]) |-> wait_r ##1 (wait_r && !PREADY_OUT);
    endproperty
    a_latch: assert property (p_latch) else $error("wait latch not set");

    property p_end_clear;
        end_pulse |=> !rf_act_r && !wait_r;
    endproperty
    a_end_clear: assert property (p_end_clear) else $error("end pulse did not clear");

    property p_cas_off;
        (rf_act_r || !bsel) |-> CAS_N_OUT == '1;
    endproperty
    a_cas_off: assert property (p_cas_off) else $error("column strobe not suppressed");

    property p_row_addr;
        rf_act_r && !RAS_N_OUT |-> MA_OUT == row_r;
    endproperty
    a_row_addr: assert property (p_row_addr) else $error("refresh row not driven");

    property p_row_inc;
        end_pulse && rf_act_r |=> row_r == drw_inc($past(row_r));
    endproperty
    a_row_inc: assert property (p_row_inc) else $error("row counter not incremented");

    property p_phantom;
        !phantom_n |-> !DI_OE_OUT;
    endproperty
    a_phantom: assert property (p_phantom) else $error("driver on during overlay");

    property p_strobe;
        rf_trig |-> ##[1:30] rf_act_r;
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe refresh not started");

    property p_dma;
        dma && acc && !acc_prev_r && state_r == drw_pkg::DRW_IDLE && !rf_req |-> ##[1:2] !RAS_N_OUT;
    endproperty
    a_dma: assert property (p_dma) else $error("DMA access gave no row strobe");

    c_forced: cover property (sr_r[`DRW_FORCE_STAGE] ##[1:3] rf_act_r);
    c_dma_unsel: cover property (dma && !bsel && !RAS_N_OUT);
    c_strobe: cover property (rf_trig ##[1:30] end_pulse);
    c_div8: cover property (div8 && adv);
endmodule : drw_refresh_ctrl

// ### rtl/drw_sync.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Two-flop synchroniser for bus pins
// ----------------------------------------------------------------
module drw_sync #(
    parameter int W = 1
) (
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_nxt;

    // Only the second stage reads the first
    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            meta_r <= '0;
            q_out <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_out <= q_nxt;
        end
    end
endmodule : drw_sync
